/* File: include/mdec_cfg.svh */
`ifndef MDEC_CFG_SVH
`define MDEC_CFG_SVH
`define MDEC_OFF_X      8'h00
`define MDEC_OFF_Y      8'h04
`define MDEC_OFF_T      8'h08
`define MDEC_OFF_L      8'h0C
`define MDEC_OFF_FADDR  8'h10
`define MDEC_OFF_FLEN   8'h14
`define MDEC_OFF_SLEN   8'h18
`define MDEC_OFF_COND   8'h1C
`define MDEC_OFF_ERRLOG 8'h20
`define MDEC_OFF_STATUS 8'h24
`define MDEC_OFF_MASK   8'h28
`define MDEC_OFF_NANO   8'h2C
`define MDEC_OFF_REGSEL 8'h30
`define MDEC_OFF_REGVAL 8'h34
`define MDEC_OFF_CTRL   8'h38
`define MDEC_RST_WORD   24'h000000
`define MDEC_RST_MASK   6'h00
`define MDEC_TOP_DIAG   8'h0B
`define MDEC_TOP_NANO   8'h0A
`define MDEC_TOP_CARRY  12'h006
`define MDEC_DG_READ    6'h00
`define MDEC_DG_WRITE   6'h04
`define MDEC_DG_ECHO    6'h09
`define MDEC_DG_AFWD    6'h0A
`define MDEC_DG_ABCK    6'h2A
`define MDEC_DG_RCLR    6'h0B
`define MDEC_DG_PLAT    6'h18
`define MDEC_DG_PECH0   6'h38
`define MDEC_DG_PECH3   6'h3B
`define MDEC_SYN_LSB    0
`define MDEC_LOC_LSB    6
`endif

/* File: include/mdec_pkg.sv */
package mdec_pkg;
    typedef enum logic [3:0] {
        MDEC_OP_NONE = 4'h0,
        MDEC_OP_READ = 4'h1,
        MDEC_OP_WRITE = 4'h2,
        MDEC_OP_ECHO = 4'h3,
        MDEC_OP_AFWD = 4'h4,
        MDEC_OP_ABCK = 4'h5,
        MDEC_OP_RCLR = 4'h6,
        MDEC_OP_PLAT = 4'h7,
        MDEC_OP_PECH = 4'h8
    } mdec_diag_t;
    typedef enum logic [0:0] {
        MDEC_ST_RUN   = 1'b0,
        MDEC_ST_MWAIT = 1'b1
    } mdec_state_t;
endpackage : mdec_pkg

/* File: rtl/mdec_cond.sv */
`timescale 1ns/1ps
`default_nettype none
// 4-bit pseudoregisters; bit 0 of each is the leftmost (msb) position
module mdec_cond #(
    parameter int DW = 24
) (
    input  wire logic [DW-1:0] x,
    input  wire logic [DW-1:0] y,
    input  wire logic [DW-1:0] len,
    input  wire logic [DW-1:0] saved,
    input  wire logic          any_int,
    output logic      [3:0]    operand_compare_bits,
    output logic      [3:0]    operand_status_bits,
    output logic      [3:0]    length_compare_bits,
    output logic               carry_from_difference,
    output logic               carry_from_logic
);
    logic [DW:0] diff;
    assign diff = {1'b0, x} - {1'b0, y};
    // borrow of x - y
    assign carry_from_difference = diff[DW];
    assign carry_from_logic = |(x & y);
    assign operand_compare_bits = {x[DW-1], x == y, x < y, x > y};
    assign operand_status_bits = {x[0], any_int, |y, |x};
    assign length_compare_bits = {len == saved, len > saved, len < saved,
                                  |len};
endmodule : mdec_cond
`default_nettype wire

/* File: rtl/mdec_ahb.sv */
`timescale 1ns/1ps
`default_nettype none
// reads take one wait state so that hrdata leaves a flip-flop
module mdec_ahb (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    input  wire logic [31:0] rd_data,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [7:0]       rd_addr
);
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_addr;
    logic       take;
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr <= take && hwrite;
            ph_rd <= take && !hwrite;
            if (take) begin
                ph_addr <= {haddr[7:2], 2'b00};
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= !(take && !hwrite);
            if (ph_rd) begin
                hrdata <= rd_data;
            end
        end
    end
    assign wr_en = ph_wr;
    assign wr_addr = ph_addr;
    assign wr_data = hwdata;
    assign rd_addr = ph_addr;
endmodule : mdec_ahb
`default_nettype wire

/* File: rtl/mdec_top.sv */
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mdec_cfg.svh"
// Contract
// - diagnostic read: 22-bit word into Y unmodified
// - diagnostic write: 22-bit word from source register
// - echo write: source through write path to Y
// - forward address echo: modified field_addr to Y
// - source code 0..3 selects X, Y, T, L
// - nano move latches abort, sequence, register, portion as one undecoded 8-bit field
// - carry_bit from difference, logic, one or zero
// - error log: board/row upper, syndrome low six
// - console bits: lamp, clock, bus, panel interrupts
// - memory bits: read error, override, read/write limits
// - operand compare and status pseudoregisters
// - group/select addressing of four register classes
module mdec_top #(
    parameter int DW = 24,
    parameter int MW = 22
) (
    input  wire logic          CLK_SYS,
    input  wire logic          RST,
    input  wire logic [15:0]   MI_WORD,
    input  wire logic          MI_VALID,
    output logic               MI_READY,
    output logic [DW-1:0]      MEM_ADDR,
    output logic [MW-1:0]      MEM_WDATA,
    output logic               MEM_WE,
    output logic               MEM_RE,
    input  wire logic [MW-1:0] MEM_RDATA,
    input  wire logic          MEM_ERR,
    input  wire logic [5:0]    MEM_ERR_LOC,
    input  wire logic [5:0]    MEM_ERR_SYN,
    input  wire logic          RD_LIMIT_EVT,
    input  wire logic          WR_LIMIT_EVT,
    input  wire logic          RTC_EVT,
    input  wire logic          IOBUS_EVT,
    input  wire logic          PANEL_EVT,
    input  wire logic [DW-1:0] PORT_LATCH,
    input  wire logic          HSEL,
    input  wire logic [7:0]    HADDR,
    input  wire logic [1:0]    HTRANS,
    input  wire logic          HWRITE,
    input  wire logic [2:0]    HSIZE,
    input  wire logic          HREADY,
    input  wire logic [31:0]   HWDATA,
    output logic [31:0]        HRDATA,
    output logic               HREADYOUT,
    output logic               HRESP,
    output logic               IRQ
);
    logic [DW-1:0] x, y, t, l, field_addr, field_len, saved_len;
    logic [DW-1:0] err_log;
    logic          err_held;
    logic          carry_bit;
    logic [7:0]    nano_reg;
    logic [5:0]    status, mask, next_status, next_mask;
    logic [5:0]    regsel;
    logic [1:0]    ctrl;
    logic [3:0]    operand_compare_bits, operand_status_bits;
    logic [3:0]    length_compare_bits, console_irq_bits, memory_irq_bits;
    logic          carry_from_difference, carry_from_logic, any_int;
    logic          bus_wr;
    logic [7:0]    bus_waddr, bus_raddr;
    logic [31:0]   bus_wdata, bus_rdata;
    logic          take;
    logic [DW-1:0] src;
    logic [MW-1:0] src_w;
    mdec_pkg::mdec_state_t state;
    mdec_pkg::mdec_diag_t  op;

    function automatic logic [DW-1:0] pick_src(input logic [1:0] code,
        input logic [DW-1:0] a, input logic [DW-1:0] b,
        input logic [DW-1:0] c, input logic [DW-1:0] d);
        case (code)
            2'h0: pick_src = a;
            2'h1: pick_src = b;
            2'h2: pick_src = c;
            default: pick_src = d;
        endcase
    endfunction : pick_src

    // select 0 nibbles, 1 condition nibbles, 2 main, 3 combinational
    function automatic logic [DW-1:0] reg_at(input logic [5:0] gs);
        logic [DW-1:0] v;
        v = '0;
        case (gs[1:0])
            2'h0: begin
                if (gs[5:2] == 4'hE) v = {20'h00000, console_irq_bits};
                else if (gs[5:2] == 4'hF) v = {20'h00000, memory_irq_bits};
                else if (gs[5:2] < 4'h6) v = {20'h00000, t[gs[4:2]*4 +: 4]};
            end
            2'h1: begin
                if (gs[5:2] == 4'h7) v = {20'h00000, length_compare_bits};
                else if (gs[5:2] == 4'hC) v = {20'h00000, operand_compare_bits};
                else if (gs[5:2] == 4'hD) v = {20'h00000, operand_status_bits};
            end
            2'h2: begin
                case (gs[5:2])
                    4'h0: v = x;
                    4'h1: v = y;
                    4'h2: v = t;
                    4'h3: v = l;
                    4'h8: v = field_addr;
                    4'hA: v = field_len;
                    default: v = '0;
                endcase
            end
            default: begin
                case (gs[5:2])
                    4'h0: v = x + y;
                    4'h1: v = ~x;
                    4'h2: v = ~y;
                    4'h7: v = x | y;
                    4'h8: v = x - y;
                    default: v = '0;
                endcase
            end
        endcase
        return v;
    endfunction : reg_at

    assign take = MI_VALID && MI_READY && (state == mdec_pkg::MDEC_ST_RUN);
    assign src = pick_src(MI_WORD[7:6], x, y, t, l);
    assign src_w = src[MW-1:0];

    always_comb begin
        op = mdec_pkg::MDEC_OP_NONE;
        if (take && MI_WORD[15:8] == `MDEC_TOP_DIAG) begin
            case (MI_WORD[5:0])
                `MDEC_DG_READ: op = mdec_pkg::MDEC_OP_READ;
                `MDEC_DG_WRITE: op = mdec_pkg::MDEC_OP_WRITE;
                `MDEC_DG_ECHO: op = mdec_pkg::MDEC_OP_ECHO;
                `MDEC_DG_AFWD: op = mdec_pkg::MDEC_OP_AFWD;
                `MDEC_DG_ABCK: op = mdec_pkg::MDEC_OP_ABCK;
                `MDEC_DG_RCLR: op = mdec_pkg::MDEC_OP_RCLR;
                `MDEC_DG_PLAT: op = mdec_pkg::MDEC_OP_PLAT;
                default: begin
                    if (MI_WORD[5:2] == 4'hE) op = mdec_pkg::MDEC_OP_PECH;
                    else op = mdec_pkg::MDEC_OP_NONE;
                end
            endcase
        end
    end

    mdec_cond #(.DW(DW)) u_cond (
        .x                     (x),
        .y                     (y),
        .len                   (field_len),
        .saved                 (saved_len),
        .any_int               (any_int),
        .operand_compare_bits  (operand_compare_bits),
        .operand_status_bits   (operand_status_bits),
        .length_compare_bits   (length_compare_bits),
        .carry_from_difference (carry_from_difference),
        .carry_from_logic      (carry_from_logic)
    );

    mdec_ahb u_ahb (
        .clk       (CLK_SYS),
        .rst       (RST),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hready    (HREADY),
        .hwdata    (HWDATA),
        .rd_data   (bus_rdata),
        .hreadyout (HREADYOUT),
        .hrdata    (HRDATA),
        .wr_en     (bus_wr),
        .wr_addr   (bus_waddr),
        .wr_data   (bus_wdata),
        .rd_addr   (bus_raddr)
    );
    assign HRESP = 1'b0;

    // leftmost bit of each nibble is bit 0
    assign console_irq_bits = {ctrl[0], status[0], status[1], status[2]};
    assign memory_irq_bits = {status[3], ctrl[1], status[4], status[5]};
    // lamp, clock and bus of the console set; panel does not count
    assign any_int = |console_irq_bits[3:1] | memory_irq_bits[3]
                   | memory_irq_bits[0];

    // sequencer: diagnostic read holds the stream for one wait cycle
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= mdec_pkg::MDEC_ST_RUN;
            MI_READY <= 1'b1;
            MEM_RE <= 1'b0;
        end else begin
            case (state)
                mdec_pkg::MDEC_ST_RUN: begin
                    if (op == mdec_pkg::MDEC_OP_READ) begin
                        state <= mdec_pkg::MDEC_ST_MWAIT;
                        MI_READY <= 1'b0;
                        MEM_RE <= 1'b1;
                    end
                end
                mdec_pkg::MDEC_ST_MWAIT: begin
                    state <= mdec_pkg::MDEC_ST_RUN;
                    MI_READY <= 1'b1;
                    MEM_RE <= 1'b0;
                end
                default: begin
                    state <= mdec_pkg::MDEC_ST_RUN;
                    MI_READY <= 1'b1;
                    MEM_RE <= 1'b0;
                end
            endcase
        end
    end

    // memory port; echo drives write data but never the strobe
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            MEM_ADDR <= '0;
            MEM_WDATA <= '0;
            MEM_WE <= 1'b0;
        end else begin
            MEM_WE <= (op == mdec_pkg::MDEC_OP_WRITE);
            if (op == mdec_pkg::MDEC_OP_READ || op == mdec_pkg::MDEC_OP_WRITE) begin
                MEM_ADDR <= field_addr;
            end
            if (op == mdec_pkg::MDEC_OP_WRITE || op == mdec_pkg::MDEC_OP_ECHO
                || op == mdec_pkg::MDEC_OP_PECH) begin
                MEM_WDATA <= src_w;
            end
        end
    end

    // Y: microinstruction results beat a bus write in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            y <= `MDEC_RST_WORD;
        end else if (state == mdec_pkg::MDEC_ST_MWAIT) begin
            y <= {{(DW-MW){1'b0}}, MEM_RDATA};
        end else begin
            case (op)
                mdec_pkg::MDEC_OP_ECHO,
                mdec_pkg::MDEC_OP_PECH: y <= {{(DW-MW){1'b0}}, src_w};
                mdec_pkg::MDEC_OP_AFWD: y <= field_addr + field_len;
                mdec_pkg::MDEC_OP_ABCK: y <= field_addr - field_len;
                mdec_pkg::MDEC_OP_RCLR: y <= err_log;
                mdec_pkg::MDEC_OP_PLAT: y <= PORT_LATCH;
                default: begin
                    if (bus_wr && bus_waddr == `MDEC_OFF_Y) y <= bus_wdata[DW-1:0];
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            x <= `MDEC_RST_WORD;
            t <= `MDEC_RST_WORD;
            l <= `MDEC_RST_WORD;
            field_addr <= `MDEC_RST_WORD;
            field_len <= `MDEC_RST_WORD;
            saved_len <= `MDEC_RST_WORD;
            regsel <= 6'h00;
            ctrl <= 2'h0;
            mask <= `MDEC_RST_MASK;
        end else if (bus_wr) begin
            case (bus_waddr)
                `MDEC_OFF_X: x <= bus_wdata[DW-1:0];
                `MDEC_OFF_T: t <= bus_wdata[DW-1:0];
                `MDEC_OFF_L: l <= bus_wdata[DW-1:0];
                `MDEC_OFF_FADDR: field_addr <= bus_wdata[DW-1:0];
                `MDEC_OFF_FLEN: field_len <= bus_wdata[DW-1:0];
                `MDEC_OFF_SLEN: saved_len <= bus_wdata[DW-1:0];
                `MDEC_OFF_REGSEL: regsel <= bus_wdata[5:0];
                `MDEC_OFF_CTRL: ctrl <= bus_wdata[1:0];
                `MDEC_OFF_MASK: mask <= bus_wdata[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            carry_bit <= 1'b0;
            nano_reg <= 8'h00;
        end else if (take) begin
            if (MI_WORD[15:4] == `MDEC_TOP_CARRY) begin
                if (MI_WORD[3]) carry_bit <= carry_from_difference;
                else if (MI_WORD[2]) carry_bit <= carry_from_logic;
                else if (MI_WORD[1]) carry_bit <= 1'b1;
                else if (MI_WORD[0]) carry_bit <= 1'b0;
            end
            if (MI_WORD[15:8] == `MDEC_TOP_NANO) begin
                nano_reg <= MI_WORD[7:0];
            end
        end
    end

    // first error is held until read-and-clear; a new error wins
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            err_log <= `MDEC_RST_WORD;
            err_held <= 1'b0;
        end else if (MEM_ERR && (!err_held || op == mdec_pkg::MDEC_OP_RCLR)) begin
            err_log <= {12'h000, MEM_ERR_LOC, MEM_ERR_SYN};
            err_held <= 1'b1;
        end else if (op == mdec_pkg::MDEC_OP_RCLR) begin
            err_log <= `MDEC_RST_WORD;
            err_held <= 1'b0;
        end
    end

    // a mask write counts at once, so IRQ tracks status & mask exactly
    assign next_mask = (bus_wr && bus_waddr == `MDEC_OFF_MASK) ? bus_wdata[5:0]
                                                               : mask;

    always_comb begin
        next_status = status;
        if (bus_wr && bus_waddr == `MDEC_OFF_STATUS) begin
            next_status = status & ~bus_wdata[5:0];
        end
        // set beats the write-one clear
        next_status = next_status | {WR_LIMIT_EVT, RD_LIMIT_EVT, MEM_ERR,
                                     PANEL_EVT, IOBUS_EVT, RTC_EVT};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            status <= 6'h00;
            IRQ <= 1'b0;
        end else begin
            status <= next_status;
            IRQ <= |(next_status & next_mask);
        end
    end

    always_comb begin
        case (bus_raddr)
            `MDEC_OFF_X: bus_rdata = {8'h00, x};
            `MDEC_OFF_Y: bus_rdata = {8'h00, y};
            `MDEC_OFF_T: bus_rdata = {8'h00, t};
            `MDEC_OFF_L: bus_rdata = {8'h00, l};
            `MDEC_OFF_FADDR: bus_rdata = {8'h00, field_addr};
            `MDEC_OFF_FLEN: bus_rdata = {8'h00, field_len};
            `MDEC_OFF_SLEN: bus_rdata = {8'h00, saved_len};
            `MDEC_OFF_COND: bus_rdata = {11'h000, carry_bit, memory_irq_bits,
                console_irq_bits, length_compare_bits, operand_status_bits,
                operand_compare_bits};
            `MDEC_OFF_ERRLOG: bus_rdata = {7'h00, err_held, err_log};
            `MDEC_OFF_STATUS: bus_rdata = {26'h0000000, status};
            `MDEC_OFF_MASK: bus_rdata = {26'h0000000, mask};
            `MDEC_OFF_NANO: bus_rdata = {24'h000000, nano_reg};
            `MDEC_OFF_REGSEL: bus_rdata = {26'h0000000, regsel};
            `MDEC_OFF_REGVAL: bus_rdata = {8'h00, reg_at(regsel)};
            `MDEC_OFF_CTRL: bus_rdata = {30'h00000000, ctrl};
            default: bus_rdata = 32'h00000000;
        endcase
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    property p_rd_y;
        state == mdec_pkg::MDEC_ST_MWAIT |=> y == {2'h0, $past(MEM_RDATA)};
    endproperty
    a_rd_y: assert property (p_rd_y) else $error("read word not in Y");
    property p_wr;
        op == mdec_pkg::MDEC_OP_WRITE |=> MEM_WE && MEM_WDATA == $past(src_w)
            && MEM_ADDR == $past(field_addr) ##1 !MEM_WE;
    endproperty
    a_wr: assert property (p_wr) else $error("write pulse wrong");
    property p_echo;
        op == mdec_pkg::MDEC_OP_ECHO |=> !MEM_WE && y == {2'h0, $past(src_w)};
    endproperty
    a_echo: assert property (p_echo) else $error("echo wrong");
    property p_afwd;
        op == mdec_pkg::MDEC_OP_AFWD |=> y == $past(field_addr + field_len);
    endproperty
    a_afwd: assert property (p_afwd) else $error("fwd addr wrong");
    property p_src;
        op == mdec_pkg::MDEC_OP_ECHO && MI_WORD[7:6] == 2'h3
            |=> y[MW-1:0] == $past(l[MW-1:0]);
    endproperty
    a_src: assert property (p_src) else $error("source code wrong");
    property p_nano;
        take && MI_WORD[15:8] == `MDEC_TOP_NANO |=> nano_reg == $past(MI_WORD[7:0]);
    endproperty
    a_nano: assert property (p_nano) else $error("nano fields");
    property p_carry;
        take && MI_WORD[15:4] == `MDEC_TOP_CARRY && MI_WORD[3:1] == 3'h1
            |=> carry_bit;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not set");
    property p_err;
        MEM_ERR && !err_held |=> err_log[5:0] == $past(MEM_ERR_SYN) && err_held;
    endproperty
    a_err: assert property (p_err) else $error("syndrome not logged");
    property p_undef;
        take && MI_WORD[15:8] == `MDEC_TOP_DIAG && op == mdec_pkg::MDEC_OP_NONE
            && !bus_wr |=> $stable(y) && !MEM_WE && !MEM_RE;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined op acted");
    property p_ready;
        MEM_RE |-> !MI_READY ##1 MI_READY && !MEM_RE;
    endproperty
    a_ready: assert property (p_ready) else $error("wait not one cycle");
    property p_irq;
        IRQ == |(status & mask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
endmodule : mdec_top
`default_nettype wire

/* File: tb/mdec_store.sv */
`timescale 1ns/1ps
`default_nettype none
// microprogram store plus the memory that answers reads
module mdec_store (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic [21:0] rd_word,
    input  wire logic        mi_ready,
    input  wire logic        mem_re,
    output logic             mi_valid,
    output logic [15:0]      mi_word,
    output logic [21:0]      mem_rdata
);
    always_ff @(posedge clk) begin
        if (rst) begin
            mi_valid <= 1'h0;
            mi_word  <= 16'h0000;
        end else if (go) begin
            mi_valid <= 1'h1;
            mi_word  <= word;
        end else if (mi_valid && mi_ready) begin
            mi_valid <= 1'h0;
            // no stale word left on the lines after the take
            mi_word  <= ~mi_word;
        end
    end
    // read data good only in the read cycle, junk elsewhere
    assign mem_rdata = mem_re ? rd_word : ~rd_word;
endmodule : mdec_store
`default_nettype wire

/* File: tb/test_microinstruction_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdec_cfg.svh"
module test_microinstruction_decoder;
    logic        CLK_SYS, RST, MI_VALID, MI_READY, MEM_WE, MEM_RE;
    logic        MEM_ERR, HSEL, HWRITE, HREADYOUT, IRQ, go, rd_ph;
    logic [1:0]  HTRANS;
    logic [3:0]  cy;
    logic [4:0]  evt;
    logic [5:0]  err_loc, err_syn;
    logic [7:0]  HADDR;
    logic [15:0] MI_WORD, word;
    logic [21:0] MEM_WDATA, MEM_RDATA, rd_word;
    logic [23:0] MEM_ADDR, PORT_LATCH;
    logic [31:0] HWDATA, HRDATA, faddr, flen, rv[4];
    logic [63:0] x;
    logic [63:0] q_rd[$];
    logic [45:0] q_mem[$];
    int          errors, samples_checked, i;

    mdec_top DUT (
        .CLK_SYS(CLK_SYS), .RST(RST), .MI_WORD(MI_WORD),
        .MI_VALID(MI_VALID), .MI_READY(MI_READY), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE),
        .MEM_RDATA(MEM_RDATA), .MEM_ERR(MEM_ERR), .MEM_ERR_LOC(err_loc),
        .MEM_ERR_SYN(err_syn), .RD_LIMIT_EVT(evt[3]),
        .WR_LIMIT_EVT(evt[4]), .RTC_EVT(evt[0]), .IOBUS_EVT(evt[1]),
        .PANEL_EVT(evt[2]), .PORT_LATCH(PORT_LATCH), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(), .IRQ(IRQ));
    mdec_store store (
        .clk(CLK_SYS), .rst(RST), .go(go), .word(word), .rd_word(rd_word),
        .mi_ready(MI_READY), .mem_re(MEM_RE), .mi_valid(MI_VALID),
        .mi_word(MI_WORD), .mem_rdata(MEM_RDATA));

    task automatic close_out;
        $display("errors %0d checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic cmp(input string nm, input logic [45:0] e,
                       input logic [45:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic step_until(input bit bus);
        int n;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while ((bus ? HREADYOUT : !MI_VALID) !== 1'h1 && n < 64);
        if ((bus ? HREADYOUT : !MI_VALID) !== 1'h1) begin
            errors++;
            close_out();
        end
    endtask : step_until

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        HSEL   <= 1'h1;
        HTRANS <= 2'h2;
        HADDR  <= a;
        HWRITE <= wr;
        step_until(1);
        HSEL   <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        step_until(1);
    endtask : ahb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
        q_rd.push_back({m, e});
        ahb(1'h0, a, 32'h0);
    endtask : rd

    // two idle edges after the take cover the gap after a memory read
    task automatic mi(input logic [15:0] w);
        word <= w;
        go   <= 1'h1;
        @(posedge CLK_SYS);
        go <= 1'h0;
        step_until(0);
        repeat (2) @(posedge CLK_SYS);
    endtask : mi

    always @(posedge CLK_SYS) begin
        if (rd_ph && HREADYOUT) begin
            x = q_rd.pop_front();
            cmp("read data", 46'(x[31:0]), 46'(HRDATA & x[63:32]));
        end
        if (HREADYOUT)
            rd_ph = HSEL && HTRANS[1] && !HWRITE;
        // an empty queue means no write was due
        if (MEM_WE)
            cmp("memory write", q_mem.size() > 0 ? q_mem.pop_front() : '1,
                {MEM_ADDR, MEM_WDATA});
    end

    initial begin
        CLK_SYS = 1'h0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        RST = 1'h1;
        {go, HSEL, HWRITE, MEM_ERR, evt, err_loc, err_syn, rd_ph} = '0;
        {word, HADDR, HTRANS, HWDATA, rd_word, PORT_LATCH} = '0;
        errors = 0;
        samples_checked = 0;
        void'($urandom(32'hB4FE));
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'h0;
        @(posedge CLK_SYS);
        cmp("idle outputs", {MI_READY, HREADYOUT, IRQ}, 46'h6);
        rd(`MDEC_OFF_X, 32'h0);
        for (i = 0; i < 4; i++) begin
            rv[i] = 32'($urandom) & 32'h3FFFFF;
            ahb(1'h1, 8'(4 * i), rv[i]);
        end
        faddr = 32'($urandom) & 32'hFFFFFF;
        flen = 32'($urandom) & 32'hFFFFFF;
        ahb(1'h1, `MDEC_OFF_FADDR, faddr);
        ahb(1'h1, `MDEC_OFF_FLEN, flen);
        ahb(1'h1, 8'h3C, 32'h5);
        rd(8'h3C, 32'h0);
        for (i = 0; i < 4; i++) begin
            q_mem.push_back({faddr[23:0], rv[i][21:0]});
            mi({`MDEC_TOP_DIAG, 2'(i), `MDEC_DG_WRITE});
        end
        for (i = 0; i < 4; i++) begin
            mi({`MDEC_TOP_DIAG, 2'(i), `MDEC_DG_ECHO});
            rv[1] = rv[i];
            rd(`MDEC_OFF_Y, rv[1]);
        end
        mi({`MDEC_TOP_DIAG, 2'h0, `MDEC_DG_AFWD});
        rd(`MDEC_OFF_Y, (faddr + flen) & 32'hFFFFFF);
        mi({`MDEC_TOP_DIAG, 2'h0, `MDEC_DG_ABCK});
        rd(`MDEC_OFF_Y, (faddr - flen) & 32'hFFFFFF);
        PORT_LATCH <= 24'($urandom);
        mi({`MDEC_TOP_DIAG, 2'h0, `MDEC_DG_PLAT});
        rd(`MDEC_OFF_Y, 32'(PORT_LATCH));
        mi({`MDEC_TOP_DIAG, 2'h2, `MDEC_DG_PECH3});
        rd(`MDEC_OFF_Y, rv[2]);
        rd_word <= 22'($urandom);
        mi({`MDEC_TOP_DIAG, 2'h0, `MDEC_DG_READ});
        rd(`MDEC_OFF_Y, 32'(rd_word));
        for (i = 0; i < 3; i++) begin
            mi({`MDEC_TOP_DIAG, 2'(i), 6'h3F - 6'(16 * i)});
            rd(`MDEC_OFF_Y, 32'(rd_word));
        end
        cy = {rv[0] < 32'(rd_word), |(rv[0] & 32'(rd_word)), 2'h2};
        for (i = 0; i < 4; i++) begin
            mi({`MDEC_TOP_CARRY, 4'h8 >> i});
            rd(`MDEC_OFF_COND, 32'(cy[3 - i]) << 20, 32'h100000);
        end
        rd(`MDEC_OFF_COND, {1'h0, rv[0] == 32'(rd_word), cy[3],
           rv[0] > 32'(rd_word)}, 32'hF);
        rd(`MDEC_OFF_COND, 32'h500, 32'hF00);
        mi({`MDEC_TOP_NANO, 8'hA5});
        rd(`MDEC_OFF_NANO, 32'hA5);
        ahb(1'h1, `MDEC_OFF_REGSEL, 32'h22);
        rd(`MDEC_OFF_REGVAL, faddr);
        for (i = 0; i < 5; i++) begin
            evt <= 5'(1 << i);
            @(posedge CLK_SYS);
            evt <= 5'h00;
            rd(`MDEC_OFF_STATUS, 32'(1 << (i + (i > 2))));
            rd(`MDEC_OFF_COND, (32'h1 << (i < 3 ? 14 - i : 20 - i))
               | (32'(i != 2 && i != 3) << 6), 32'hFF040);
            cmp("masked irq", 46'(IRQ), 46'h0);
            ahb(1'h1, `MDEC_OFF_MASK, 32'h3F);
            repeat (2) @(posedge CLK_SYS);
            cmp("irq", 46'(IRQ), 46'h1);
            ahb(1'h1, `MDEC_OFF_STATUS, 32'(1 << (i + (i > 2))));
            ahb(1'h1, `MDEC_OFF_MASK, 32'h0);
            repeat (2) @(posedge CLK_SYS);
            cmp("cleared irq", 46'(IRQ), 46'h0);
        end
        {err_loc, err_syn} <= 12'($urandom);
        MEM_ERR <= 1'h1;
        @(posedge CLK_SYS);
        MEM_ERR <= 1'h0;
        rd(`MDEC_OFF_ERRLOG, 32'h1000000 | 32'({err_loc, err_syn}));
        rd(`MDEC_OFF_STATUS, 32'h8, 32'h8);
        mi({`MDEC_TOP_DIAG, 2'h0, `MDEC_DG_RCLR});
        rd(`MDEC_OFF_Y, 32'({err_loc, err_syn}));
        rd(`MDEC_OFF_ERRLOG, 32'h0);
        repeat (4) @(posedge CLK_SYS);
        close_out();
    end
endmodule : test_microinstruction_decoder
`default_nettype wire
